// ### core/mac_pkg.sv
// Shared constants and types for the 16x16 multiply-accumulator.
package mac_pkg;

  // ****************************************************************
  // Widths and field positions of the result register
  // ****************************************************************
  localparam int OP_W = 16;
  localparam int EXT_W = 3;
  localparam int ACC_W = 35;
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 16;
  localparam int EXT_LSB = 32;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [34:0] ACC_RST = 35'h0;
  localparam logic [15:0] OPND_RST = 16'h0;
  localparam logic OE_RST = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int MAC_TIME_NS = 55;
  localparam int MAC_CYCLES_RAW = MAC_TIME_NS / CLK_PERIOD_NS;
  localparam int MAC_CYCLES = (MAC_CYCLES_RAW < 1) ? 1 : MAC_CYCLES_RAW;
  // Cycles from an accepted result strobe to the updated accumulator.
  localparam int MAC_LATENCY = 1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic tc;
    logic accum;
    logic sub;
    logic prel;
  } mac_ctrl_t;

  localparam mac_ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic [2:0] result_extension_bits;
    logic [15:0] high_result_word;
    logic [15:0] low_result_word;
  } mac_result_t;

  typedef enum logic [2:0] {
    MAC_HOLD,
    MAC_LOAD,
    MAC_ADD,
    MAC_SUB,
    MAC_PRELOAD
  } mac_op_t;

endpackage : mac_pkg

// ### core/mac_mult.sv
// Operand multiplier that extends the product to the accumulator width.
`timescale 1ns/10ps
`default_nettype none
module mac_mult #(
  parameter int OP_W = 16,   // Operand width.
  parameter int EXT_W = 3    // Guard bits above the product.
) (
  input wire logic [OP_W-1:0] x,               // X operand.
  input wire logic [OP_W-1:0] y,               // Y operand.
  input wire logic tc,                         // High for two's complement.
  output logic [2*OP_W+EXT_W-1:0] prod_ext     // Extended product.
);
  localparam int PW = 2 * OP_W + 2;
  localparam int AW = 2 * OP_W + EXT_W;

  // The extended product needs at least one bit above the signed
  // product, or the extension replication would be empty.
  if (OP_W < 2 || EXT_W < 3) begin : g_bad_width
    $error("mac_mult: OP_W must be >= 2 and EXT_W >= 3");
  end

  logic signed [OP_W:0] xs;
  logic signed [OP_W:0] ys;
  logic signed [PW-1:0] prod;

  // One extra operand bit lets one signed multiplier serve both modes:
  // it holds the sign in two's complement and a zero when unsigned.
  always_comb begin
    xs = $signed({tc & x[OP_W-1], x});
    ys = $signed({tc & y[OP_W-1], y});
    prod = xs * ys;
    // Unsigned products have a zero top bit, so this zero-extends them.
    prod_ext = {{(AW-PW){prod[PW-1]}}, prod};
  end

endmodule : mac_mult
`default_nettype wire

// ### core/mac_accum.sv
// Next-value logic of the accumulator: load, add, subtract or preload.
`timescale 1ns/10ps
`default_nettype none
module mac_accum #(
  parameter int ACC_W = 35   // Accumulator width.
) (
  input wire logic [ACC_W-1:0] acc,       // Present accumulator.
  input wire logic [ACC_W-1:0] prod,      // Extended product.
  input wire logic [ACC_W-1:0] pre_val,   // Value on the result pins.
  input wire mac_pkg::mac_op_t op,        // Operation to perform.
  output logic [ACC_W-1:0] acc_next       // Next accumulator value.
);
  import mac_pkg::*;

  if (ACC_W < 4) begin : g_bad_width
    $error("mac_accum: ACC_W must be >= 4");
  end

  // Overflow wraps silently; the guard bits give eight full-scale
  // accumulations of headroom before that happens.
  always_comb begin
    case (op)
      MAC_LOAD: acc_next = prod;
      MAC_ADD: acc_next = acc + prod;
      MAC_SUB: acc_next = acc - prod;
      MAC_PRELOAD: acc_next = pre_val;
      MAC_HOLD: acc_next = acc;
      default: acc_next = acc;
    endcase
  end

endmodule : mac_accum
`default_nettype wire

// ### core/mac_top.sv
// Top of the 16x16 multiply-accumulator with a 35-bit result register.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Multiply 16-bit operands, accumulate into 35 bits.
// - Operands are two's complement or unsigned, selected.
// - Load command replaces accumulator with product.
// - Add or subtract product into accumulator.
// - Preload whole accumulator from the result pins.
// - Operands, mode controls and outputs are registered; LOAD_P and the preload pins are not.
// - Result splits into low, high, extension.
// - Extension and high word have own ports.
// - Low word shares Y pins; host releases them.
// - One multiply-accumulate per clock cycle.
module mac_top (
  input wire logic MCLK,                     // Clock.
  input wire logic RESETN,                   // Asynchronous reset.
  input wire logic CE,                       // Clock enable.
  input wire logic [mac_pkg::OP_W-1:0] X_I,  // X operand pins.
  input wire logic [mac_pkg::OP_W-1:0] Y_I,  // Y and low word, input.
  output logic [mac_pkg::OP_W-1:0] Y_O,      // Low word output.
  output logic Y_OE,                         // Low word drive enable.
  input wire logic [mac_pkg::OP_W-1:0] HIGH_I, // High word, input.
  output logic [mac_pkg::OP_W-1:0] HIGH_O,   // High word output.
  output logic HIGH_OE,                      // High word drive enable.
  input wire logic [mac_pkg::EXT_W-1:0] EXT_I, // Extension, input.
  output logic [mac_pkg::EXT_W-1:0] EXT_O,   // Extension output.
  output logic EXT_OE,                       // Extension drive enable.
  input wire logic LOAD_X,                   // Capture X operand.
  input wire logic LOAD_Y,                   // Capture Y operand.
  input wire logic LOAD_P,                   // Update the accumulator.
  input wire logic TWOS_COMP,                // Two's complement mode.
  input wire logic ACCUM,                    // Accumulate, else load.
  input wire logic SUBTRACT,                 // Subtract when accumulating.
  input wire logic PRELOAD,                  // Preload from result pins.
  input wire logic LOW_EN,                   // Allow low word drive.
  input wire logic HIGH_EN,                  // Allow high word drive.
  input wire logic EXT_EN                    // Allow extension drive.
);
  import mac_pkg::*;

  // ****************************************************************
  // Operand and control input registers
  // ****************************************************************
  logic [OP_W-1:0] x_reg;
  logic [OP_W-1:0] x_next;
  logic [OP_W-1:0] y_reg;
  logic [OP_W-1:0] y_next;
  mac_ctrl_t ctrl_reg;
  mac_ctrl_t ctrl_next;

  // Controls ride with whichever operand is captured, so a command
  // always pairs with the operands that were loaded alongside it.
  always_comb begin
    x_next = x_reg;
    y_next = y_reg;
    ctrl_next = ctrl_reg;
    if (CE) begin
      if (LOAD_X) begin
        x_next = X_I;
      end
      if (LOAD_Y) begin
        y_next = Y_I;
      end
      if (LOAD_X || LOAD_Y) begin
        ctrl_next.tc = TWOS_COMP;
        ctrl_next.accum = ACCUM;
        ctrl_next.sub = SUBTRACT;
        ctrl_next.prel = PRELOAD;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      x_reg <= OPND_RST;
      y_reg <= OPND_RST;
      ctrl_reg <= CTRL_RST;
    end else begin
      x_reg <= x_next;
      y_reg <= y_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************************************
  // Multiplier and accumulator datapath
  // ****************************************************************
  logic [ACC_W-1:0] prod_ext;
  logic [ACC_W-1:0] pin_word;
  mac_op_t op;

  mac_mult #(
    .OP_W(OP_W),
    .EXT_W(EXT_W)
  ) u_mult (
    .x(x_reg),
    .y(y_reg),
    .tc(ctrl_reg.tc),
    .prod_ext(prod_ext)
  );

  // The low word of a preload arrives on the shared Y pins.
  assign pin_word = {EXT_I, HIGH_I, Y_I};

  always_comb begin
    op = MAC_HOLD;
    if (CE && LOAD_P) begin
      if (ctrl_reg.prel) begin
        op = MAC_PRELOAD;
      end else if (!ctrl_reg.accum) begin
        op = MAC_LOAD;
      end else if (ctrl_reg.sub) begin
        op = MAC_SUB;
      end else begin
        op = MAC_ADD;
      end
    end
  end

  // ****************************************************************
  // Result register and pin drivers
  // ****************************************************************
  mac_result_t acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic y_oe_reg;
  logic y_oe_next;
  logic high_oe_reg;
  logic high_oe_next;
  logic ext_oe_reg;
  logic ext_oe_next;

  mac_accum #(
    .ACC_W(ACC_W)
  ) u_accum (
    .acc(acc_reg),
    .prod(prod_ext),
    .pre_val(pin_word),
    .op(op),
    .acc_next(acc_next)
  );

  // Drivers go quiet whenever a preload is armed, so the host can
  // place the preload value on the result pins without a fight.
  always_comb begin
    y_oe_next = y_oe_reg;
    high_oe_next = high_oe_reg;
    ext_oe_next = ext_oe_reg;
    if (CE) begin
      y_oe_next = LOW_EN && !ctrl_next.prel;
      high_oe_next = HIGH_EN && !ctrl_next.prel;
      ext_oe_next = EXT_EN && !ctrl_next.prel;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_reg <= ACC_RST;
      y_oe_reg <= OE_RST;
      high_oe_reg <= OE_RST;
      ext_oe_reg <= OE_RST;
    end else begin
      acc_reg <= acc_next;
      y_oe_reg <= y_oe_next;
      high_oe_reg <= high_oe_next;
      ext_oe_reg <= ext_oe_next;
    end
  end

  assign Y_O = acc_reg.low_result_word;
  assign HIGH_O = acc_reg.high_result_word;
  assign EXT_O = acc_reg.result_extension_bits;
  assign Y_OE = y_oe_reg;
  assign HIGH_OE = high_oe_reg;
  assign EXT_OE = ext_oe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [ACC_W-1:0] acc_flat;
  logic take_p;
  localparam int LAT = MAC_LATENCY;
  assign acc_flat = acc_reg;
  assign take_p = CE && LOAD_P;

  sequence s_load_req;
    take_p && !ctrl_reg.prel && !ctrl_reg.accum;
  endsequence

  sequence s_load_done;
    ##LAT acc_flat == $past(prod_ext, LAT);
  endsequence

  property p_load;
    @(posedge MCLK) disable iff (!RESETN)
      s_load_req |-> s_load_done;
  endproperty
  a_load: assert property (p_load)
    else $error("accumulator did not take the product");

  property p_add;
    @(posedge MCLK) disable iff (!RESETN)
      take_p && !ctrl_reg.prel && ctrl_reg.accum && !ctrl_reg.sub
      |=> acc_flat == $past(acc_flat) + $past(prod_ext);
  endproperty
  a_add: assert property (p_add)
    else $error("accumulate add gave a wrong sum");

  property p_sub;
    @(posedge MCLK) disable iff (!RESETN)
      take_p && !ctrl_reg.prel && ctrl_reg.accum && ctrl_reg.sub
      |=> acc_flat == $past(acc_flat) - $past(prod_ext);
  endproperty
  a_sub: assert property (p_sub)
    else $error("accumulate subtract gave a wrong difference");

  property p_preload;
    @(posedge MCLK) disable iff (!RESETN)
      take_p && ctrl_reg.prel |=> acc_flat == $past(pin_word);
  endproperty
  a_preload: assert property (p_preload)
    else $error("preload value not captured from the pins");

  property p_hold;
    @(posedge MCLK) disable iff (!RESETN)
      !take_p |=> $stable(acc_flat)
        && ($past(CE && LOAD_X) || $stable(x_reg));
  endproperty
  a_hold: assert property (p_hold)
    else $error("accumulator changed without a result strobe");

  property p_xcap;
    @(posedge MCLK) disable iff (!RESETN)
      CE && LOAD_X |=> x_reg == $past(X_I);
  endproperty
  a_xcap: assert property (p_xcap)
    else $error("X operand not registered");

  // Each field must come back on its own port after a preload.
  property p_split;
    @(posedge MCLK) disable iff (!RESETN)
      take_p && ctrl_reg.prel |=> Y_O == $past(Y_I)
        && HIGH_O == $past(HIGH_I) && EXT_O == $past(EXT_I);
  endproperty
  a_split: assert property (p_split)
    else $error("result pins do not show the result fields");

  property p_oe;
    @(posedge MCLK) disable iff (!RESETN)
      CE |=> (EXT_OE == $past(EXT_EN && !ctrl_next.prel))
        && (HIGH_OE == $past(HIGH_EN && !ctrl_next.prel));
  endproperty
  a_oe: assert property (p_oe)
    else $error("result drivers enabled wrongly");

  property p_low_free;
    @(posedge MCLK) disable iff (!RESETN)
      Y_OE |-> !ctrl_reg.prel;
  endproperty
  a_low_free: assert property (p_low_free)
    else $error("low word driven while preload is armed");

  property p_rate;
    @(posedge MCLK) disable iff (!RESETN)
      s_load_req ##1 s_load_req |-> ##1 acc_flat == $past(prod_ext);
  endproperty
  a_rate: assert property (p_rate)
    else $error("back to back operations not served each cycle");

  property p_ext;
    @(posedge MCLK) disable iff (!RESETN)
      1'b1 |-> prod_ext[ACC_W-1] == (ctrl_reg.tc && prod_ext[ACC_W-2])
        && prod_ext[ACC_W-1] == (ctrl_reg.tc && (x_reg[OP_W-1]
        ^ y_reg[OP_W-1]) && x_reg != OPND_RST && y_reg != OPND_RST);
  endproperty
  a_ext: assert property (p_ext)
    else $error("product extension does not follow the mode");

  property p_width;
    @(posedge MCLK) disable iff (!RESETN)
      (s_load_req and !ctrl_reg.tc) |=> acc_flat[ACC_W-1:2*OP_W] == 3'h0;
  endproperty
  a_width: assert property (p_width)
    else $error("unsigned product leaked into the extension bits");

  property p_ycap;
    @(posedge MCLK) disable iff (!RESETN)
      CE && LOAD_Y |=> y_reg == $past(Y_I);
  endproperty
  a_ycap: assert property (p_ycap)
    else $error("Y operand not registered");

  property p_mode;
    @(posedge MCLK) disable iff (!RESETN)
      CE && (LOAD_X || LOAD_Y) |=> ctrl_reg.tc == $past(TWOS_COMP);
  endproperty
  a_mode: assert property (p_mode)
    else $error("operand mode not captured with the operands");

  // A low clock enable must hold the accumulator, both operands and Y_OE, strobes or not.
  property p_freeze;
    @(posedge MCLK) disable iff (!RESETN)
      !CE |=> $stable(acc_flat) && $stable(x_reg) && $stable(y_reg)
        && $stable(Y_OE);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while the clock enable was low");

endmodule : mac_top
`default_nettype wire

// ### bench/mac_host_model.sv
// Host-side model that drives the shared result pins and resolves them.
`timescale 1ns/10ps
`default_nettype none
module mac_host_model (
  input wire logic clk,                      // Clock.
  input wire mac_pkg::mac_result_t drv_val,  // Value the host drives.
  input wire logic [2:0] drv_en,             // Host drive {ext, high, low}.
  input wire mac_pkg::mac_result_t dev_val,  // Device pin outputs.
  input wire logic [2:0] dev_en,             // Device drive {ext, high, low}.
  output mac_pkg::mac_result_t pin_val,      // Resolved pin levels.
  output logic clash                         // Both sides drove one field.
);
  import mac_pkg::*;
  mac_result_t last_reg = '0;
  logic clash_reg = 1'b0;

  assign clash = clash_reg;

  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  // Undriven pins have no pull, so they show the inverse of their last
  // level rather than a stale copy that could mask a missing capture.
  assign pin_val.low_result_word = dev_en[0] ? dev_val.low_result_word :
    drv_en[0] ? drv_val.low_result_word : ~last_reg.low_result_word;
  assign pin_val.high_result_word = dev_en[1] ? dev_val.high_result_word :
    drv_en[1] ? drv_val.high_result_word : ~last_reg.high_result_word;
  assign pin_val.result_extension_bits = dev_en[2] ?
    dev_val.result_extension_bits : drv_en[2] ?
    drv_val.result_extension_bits : ~last_reg.result_extension_bits;

  always @(posedge clk) begin
    last_reg <= pin_val;
    if ((drv_en & dev_en) != 3'h0) begin
      clash_reg <= 1'b1;
    end
  end
endmodule : mac_host_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking testbench of the multiply-accumulator top.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mac_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [15:0] x_i = 16'h0;
  logic load_x, load_y, load_p, tc, accum, sub, pre;
  logic low_en, high_en, ext_en;
  logic [15:0] y_o, high_o;
  logic [2:0] ext_o, drv_en, dev_en;
  logic y_oe, high_oe, ext_oe, clash;
  mac_result_t drv_val, dev_val, pin_val;
  int errors = 0;
  int checks_done = 0;

  assign dev_val = {ext_o, high_o, y_o};
  assign dev_en = {ext_oe, high_oe, y_oe};

  always #2 mclk = ~mclk;

  mac_top i_mac_top (
    .MCLK(mclk), .RESETN(resetn), .CE(ce), .X_I(x_i),
    .Y_I(pin_val.low_result_word), .Y_O(y_o), .Y_OE(y_oe),
    .HIGH_I(pin_val.high_result_word), .HIGH_O(high_o), .HIGH_OE(high_oe),
    .EXT_I(pin_val.result_extension_bits), .EXT_O(ext_o), .EXT_OE(ext_oe),
    .LOAD_X(load_x), .LOAD_Y(load_y), .LOAD_P(load_p), .TWOS_COMP(tc),
    .ACCUM(accum), .SUBTRACT(sub), .PRELOAD(pre),
    .LOW_EN(low_en), .HIGH_EN(high_en), .EXT_EN(ext_en));

  mac_host_model i_mac_host_model (
    .clk(mclk), .drv_val(drv_val), .drv_en(drv_en), .dev_val(dev_val),
    .dev_en(dev_en), .pin_val(pin_val), .clash(clash));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // The host may drive Y only while the low word driver is off.
  task automatic capture(input logic [15:0] x, y, input mac_ctrl_t c);
    x_i = x;
    drv_val.low_result_word = y;
    drv_en = 3'b001;
    {tc, accum, sub, pre} = c;
    load_x = 1'b1;
    load_y = 1'b1;
  endtask : capture

  // Turns all drivers on, reads the pins, then frees the Y pins again.
  task automatic read_acc(input logic [34:0] exp);
    {load_x, load_y, load_p} = 3'h0;
    drv_en = 3'h0;
    {low_en, high_en, ext_en} = 3'h7;
    tick();
    check(pin_val, exp);
    check({32'h0, dev_en}, 35'h7);
    low_en = 1'b0;
    tick();
  endtask : read_acc

  task automatic mac_once(input logic [15:0] x, y, input mac_ctrl_t c,
                          input logic [34:0] exp);
    capture(x, y, c);
    tick();
    {load_x, load_y} = 2'h0;
    drv_en = 3'h0;
    load_p = 1'b1;
    tick();
    read_acc(exp);
  endtask : mac_once

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    tick();
    tick();
    resetn = 1'b1;
    check(dev_val, 35'h0);
    check({32'h0, dev_en}, 35'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_load;
    mac_once(16'hffff, 16'hffff, 4'h0, 35'h0fffe0001);
    mac_once(16'hffff, 16'hffff, 4'h8, 35'h000000001);
    mac_once(16'h8000, 16'h0001, 4'h8, 35'h7ffff8000);
    mac_once(16'h8000, 16'h0001, 4'h0, 35'h000008000);
    $display("test load done");
  endtask : t_load

  task automatic t_accum;
    mac_once(16'h1000, 16'h1000, 4'h0, 35'h001000000);
    mac_once(16'h0010, 16'h0010, 4'h4, 35'h001000100);
    mac_once(16'h2000, 16'h0001, 4'h6, 35'h000ffe100);
    mac_once(16'h0001, 16'hffff, 4'he, 35'h000ffe101);
    $display("test accumulate done");
  endtask : t_accum

  // Nine strobes back to back; the ninth overflows the 35-bit sum.
  task automatic t_pipe;
    logic [34:0] e;
    e = 35'h0;
    {high_en, ext_en} = 2'h3;
    capture(16'hffff, 16'hffff, 4'h0);
    tick();
    capture(16'hffff, 16'hffff, 4'h4);
    load_p = 1'b1;
    for (int k = 1; k <= 9; k++) begin
      e = e + 35'h0fffe0001;
      tick();
      check({16'h0, dev_val[34:16]}, {16'h0, e[34:16]});
    end
    read_acc(e);
    $display("test back to back done");
  endtask : t_pipe

  task automatic t_preload;
    {low_en, high_en, ext_en} = 3'h7;
    capture(16'h0, 16'h0, 4'h1);
    tick();
    check({32'h0, dev_en}, 35'h0);
    {load_x, load_y} = 2'h0;
    drv_val = 35'h5a5a5c3c3;
    drv_en = 3'h7;
    load_p = 1'b1;
    tick();
    load_p = 1'b0;
    check(dev_val, 35'h5a5a5c3c3);
    check({32'h0, dev_en}, 35'h0);
    capture(16'h0, 16'h0, 4'h0);
    tick();
    read_acc(35'h5a5a5c3c3);
    $display("test preload done");
  endtask : t_preload

  // With the enable low neither operands nor strobe may take effect.
  task automatic t_freeze;
    ce = 1'b0;
    capture(16'h0003, 16'h0005, 4'h0);
    load_p = 1'b1;
    tick();
    check(dev_val, 35'h5a5a5c3c3);
    {load_x, load_y} = 2'h0;
    drv_en = 3'h0;
    ce = 1'b1;
    tick();
    load_p = 1'b0;
    check(dev_val, 35'h0);
    $display("test clock enable done");
  endtask : t_freeze

  initial begin
    {load_x, load_y, load_p, tc, accum, sub, pre} = 7'h0;
    {low_en, high_en, ext_en} = 3'h0;
    drv_val = '0;
    drv_en = 3'h0;
    t_reset();
    t_load();
    t_accum();
    t_pipe();
    t_preload();
    t_freeze();
    check({34'h0, clash}, 35'h0);
    summarize();
  end

  // A hang counts as a mismatch and goes straight to the report.
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
